// >>> rtl/ptre_pkg.sv
// Shared constants, states and state layout of the programmed-I/O responder.
package ptre_pkg;

    // Request types carried in the request descriptor.
    localparam logic [3:0] REQ_MEM_RD = 4'h0;
    localparam logic [3:0] REQ_MEM_WR = 4'h1;
    localparam logic [3:0] REQ_IO_RD = 4'h2;
    localparam logic [3:0] REQ_IO_WR = 4'h3;

    // Matched-window identifier codes.
    localparam logic [2:0] WIN_IO = 3'h0;
    localparam logic [2:0] WIN_WIDE = 3'h1;
    localparam logic [2:0] WIN_A = 3'h2;
    localparam logic [2:0] WIN_EROM = 3'h6;

    // Region numbers inside the storage array.
    localparam logic [1:0] RGN_IO = 2'h0;
    localparam logic [1:0] RGN_WIDE = 2'h1;
    localparam logic [1:0] RGN_A = 2'h2;
    localparam logic [1:0] RGN_EROM = 2'h3;

    // Storage shape: four regions of 2 KB, 512 Dwords each.
    localparam int REGIONS = 4;
    localparam int REGION_BYTES = 2048;
    localparam int REGION_DW = REGION_BYTES / 4;
    localparam int IDX_W = 9;

    // Request descriptor field positions (lowest bit of each field).
    localparam int HDR_W = 256;
    localparam int CQ_ADDR_LO = 2;
    localparam int CQ_DWCNT_LO = 64;
    localparam int CQ_DWCNT_W = 11;
    localparam int CQ_TYPE_LO = 75;
    localparam int CQ_REQID_LO = 80;
    localparam int CQ_TAG_LO = 96;
    localparam int CQ_WIN_LO = 112;
    localparam int CQ_TC_LO = 121;
    localparam int CQ_ATTR_LO = 124;
    localparam int CQ_DATA_LO = 128;

    // Completion descriptor field positions.
    localparam int CPL_W = 128;
    localparam int CC_LADDR_LO = 0;
    localparam int CC_BCNT_LO = 16;
    localparam int CC_DWCNT_LO = 32;
    localparam int CC_STAT_LO = 43;
    localparam int CC_REQID_LO = 48;
    localparam int CC_TAG_LO = 64;
    localparam int CC_CPLID_LO = 72;
    localparam int CC_TC_LO = 89;
    localparam int CC_ATTR_LO = 92;
    localparam int CC_DATA_LO = 96;
    localparam int CPL_DW_DATA = 4;
    localparam int CPL_DW_NODATA = 3;
    localparam logic [12:0] CPL_BYTES = 13'h0004;
    localparam logic [2:0] CPL_STAT_OK = 3'h0;

    // Values after reset.
    localparam logic [2:0] BEAT_RST = 3'h0;
    localparam logic [1:0] RST_SYNC_RST = 2'h0;

    typedef enum logic [2:0] {
        ST_RX,
        ST_DECODE,
        ST_WRITE,
        ST_READ,
        ST_CPL
    } ptre_state_e;

    typedef struct packed {
        ptre_state_e st;
        logic [2:0] beat;
        logic [HDR_W-1:0] hdr;
        logic [CPL_W-1:0] cpl;
        logic cpl_data;
        logic [1:0] region;
        logic [IDX_W-1:0] idx;
        logic [31:0] wdata;
        logic io_wr;
        logic mem_we;
        logic mem_rd;
        logic wr_busy;
        logic compl_done;
        logic turn_off_ok;
    } ptre_state_s;

endpackage

// >>> rtl/ptre_engine.sv
// Programmed-I/O target responder: receive, memory access, transmit, turn-off.

// How it works
// [R1] The core forwards only requests that hit a programmed window.
// [R2] The core supplies a 3-bit window id with each request.
// [R3] Window id picks which 2 KB storage region the read uses.
// [R4] Accepted reads take low address bits and start a storage read.
// [R5] Every single-Dword memory or I/O read to window id 000, 001, 010 or 110 gets a completion with data.
// [R6] Request ready stays low until read data is fetched and completion sent.
// [R7] Request ready drops right after the last beat is taken.
// [R8] Next read is taken only after completion done pulses.
// [R9] Next write is taken only after write busy falls.
// [R10] Stream width parameter supports 64, 128 and 256 bits.
// [R11] Lane count limits legal widths: x1 64, x2 up to 128.
// [R12] 128 bits with eight lanes at 8.0 Gb/s is illegal.
// [R13] Block splits into receive, memory access, transmit, turn-off parts.
// [R14] Requests longer than one Dword are swallowed without completion.
// [R15] Window id 001 is wide memory, 110 expansion ROM, own regions.
// [R16] Writes store the Dword; I/O writes also get a plain completion.
// [R17] Offsets beyond 2 KB wrap inside the region.
// [R18] Read completion echoes requester id, tag and the low seven address bits of the request.
// [R19] Storage read data is ready in the same cycle as read enable.
module ptre_engine #(
    parameter int DATA_W = 64,
    parameter int LANES = 8,
    parameter int LANE_RATE_X10 = 80,
    parameter logic [15:0] COMPLETER_ID = 16'h0000
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [DATA_W-1:0] cq_tdata,
    input wire logic cq_tvalid,
    input wire logic cq_tlast,
    output logic req_channel_ready,
    output logic [DATA_W-1:0] cc_tdata,
    output logic [DATA_W/32-1:0] cc_tkeep,
    output logic cc_tvalid,
    output logic cc_tlast,
    input wire logic cc_tready,
    output logic compl_done,
    output logic wr_busy,
    input wire logic turn_off_req,
    output logic turn_off_ok,
    output logic cfg_legal
);

    localparam int HDR_BEATS = ptre_pkg::HDR_W / DATA_W;
    localparam int CPL_BEATS = (ptre_pkg::CPL_W + DATA_W - 1) / DATA_W;
    localparam int KEEP_W = DATA_W / 32;

    // A width that the lane count does not allow still builds, but the
    // legality flag tells the integrator the pairing is out of range.
    localparam bit WIDTH_OK = (DATA_W == 64) || (DATA_W == 128) ||
        (DATA_W == 256); // see [R10]
    localparam bit LANE_OK = (LANES == 1) ? (DATA_W == 64) :
        (LANES == 2) ? (DATA_W <= 128) : 1'b1; // see [R11]
    localparam bit RATE_OK = !((DATA_W == 128) && (LANES == 8) &&
        (LANE_RATE_X10 == 80)); // see [R12]

    assign cfg_legal = WIDTH_OK && LANE_OK && RATE_OK;

    // Window id to region; unknown ids fall out as not valid.
    function automatic logic [2:0] win_to_region(input logic [2:0] win);
        case (win)
            ptre_pkg::WIN_IO: win_to_region = {1'b1, ptre_pkg::RGN_IO};
            ptre_pkg::WIN_WIDE: win_to_region = {1'b1, ptre_pkg::RGN_WIDE};
            ptre_pkg::WIN_A: win_to_region = {1'b1, ptre_pkg::RGN_A};
            ptre_pkg::WIN_EROM: win_to_region = {1'b1, ptre_pkg::RGN_EROM};
            default: win_to_region = 3'h0;
        endcase
    endfunction

    // Completion descriptor shared by read answers and I/O write answers.
    function automatic logic [ptre_pkg::CPL_W-1:0] make_cpl(
        input logic [ptre_pkg::HDR_W-1:0] hdr,
        input logic with_data,
        input logic [31:0] data,
        input logic [15:0] cpl_id
    );
        logic [ptre_pkg::CPL_W-1:0] c;
        c = '0;
        c[ptre_pkg::CC_LADDR_LO +: 7] =
            {hdr[ptre_pkg::CQ_ADDR_LO +: 5], 2'b00}; // see [R18]
        c[ptre_pkg::CC_BCNT_LO +: 13] = ptre_pkg::CPL_BYTES;
        c[ptre_pkg::CC_DWCNT_LO +: 11] = with_data ? 11'h001 : 11'h000;
        c[ptre_pkg::CC_STAT_LO +: 3] = ptre_pkg::CPL_STAT_OK;
        c[ptre_pkg::CC_REQID_LO +: 16] =
            hdr[ptre_pkg::CQ_REQID_LO +: 16]; // see [R18]
        c[ptre_pkg::CC_TAG_LO +: 8] =
            hdr[ptre_pkg::CQ_TAG_LO +: 8]; // see [R18]
        c[ptre_pkg::CC_CPLID_LO +: 16] = cpl_id;
        c[ptre_pkg::CC_TC_LO +: 3] = hdr[ptre_pkg::CQ_TC_LO +: 3];
        c[ptre_pkg::CC_ATTR_LO +: 3] = hdr[ptre_pkg::CQ_ATTR_LO +: 3];
        if (with_data) begin
            c[ptre_pkg::CC_DATA_LO +: 32] = data; // see [R5]
        end
        make_cpl = c;
    endfunction

    localparam logic [2:0] CPL_LAST = 3'(CPL_BEATS - 1);
    localparam logic [2:0] BEAT_MAX = 3'h7;
    localparam int MEM_WORDS = ptre_pkg::REGIONS * ptre_pkg::REGION_DW;

    logic [1:0] rst_sync_r;
    logic rst_int_n;
    ptre_pkg::ptre_state_s state_r;
    ptre_pkg::ptre_state_s state_nxt;
    logic [31:0] mem_r [MEM_WORDS];
    logic [3:0] req_type;
    logic [2:0] req_win;
    logic [2:0] region_sel;
    logic [ptre_pkg::CQ_DWCNT_W-1:0] req_dwcnt;
    logic one_dword;
    logic is_read;
    logic is_write;
    logic take_beat;
    logic [31:0] rd_word;
    logic [CPL_BEATS*DATA_W-1:0] cpl_pad;
    int cpl_dw_total;

    // Reset release passes two flops so every state register bit leaves reset on
    // the same edge; assertion stays asynchronous.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_r <= ptre_pkg::RST_SYNC_RST;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end

    assign rst_int_n = rst_sync_r[1];

    // Receive part: descriptor decode of the captured request.
    assign req_type = state_r.hdr[ptre_pkg::CQ_TYPE_LO +: 4];
    assign req_win = state_r.hdr[ptre_pkg::CQ_WIN_LO +: 3];
    assign req_dwcnt = state_r.hdr[ptre_pkg::CQ_DWCNT_LO +:
        ptre_pkg::CQ_DWCNT_W];
    assign region_sel = win_to_region(req_win); // see [R3] see [R15]
    assign one_dword = (req_dwcnt == 11'h001); // see [R14]
    assign is_read = (req_type == ptre_pkg::REQ_MEM_RD) ||
        (req_type == ptre_pkg::REQ_IO_RD);
    assign is_write = (req_type == ptre_pkg::REQ_MEM_WR) ||
        (req_type == ptre_pkg::REQ_IO_WR);

    // One request at a time keeps the receive side trivial; throughput is
    // the price, since ready stays low for the whole transaction.
    assign req_channel_ready = rst_int_n &&
        (state_r.st == ptre_pkg::ST_RX); // see [R6] see [R8] see [R9]
    assign take_beat = cq_tvalid && req_channel_ready;

    // Memory access part: one array holds all four regions. The read is
    // taken into the completion register in the same cycle as the read enable.
    assign rd_word = mem_r[{state_r.region, state_r.idx}]; // see [R19]

    always_ff @(posedge clk_sys) begin
        if (state_r.mem_we) begin
            mem_r[{state_r.region, state_r.idx}] <= state_r.wdata; // see [R16]
        end
    end

    // Transmit part: the completion register is sent beat by beat.
    assign cpl_pad = (CPL_BEATS * DATA_W)'(state_r.cpl);
    assign cpl_dw_total = state_r.cpl_data ? ptre_pkg::CPL_DW_DATA :
        ptre_pkg::CPL_DW_NODATA;

    always_comb begin
        cc_tdata = cpl_pad[DATA_W-1:0];
        for (int b = 1; b < CPL_BEATS; b++) begin
            if (state_r.beat == 3'(b)) begin
                cc_tdata = cpl_pad[b*DATA_W +: DATA_W];
            end
        end
    end

    always_comb begin
        cc_tkeep = '0;
        for (int k = 0; k < KEEP_W; k++) begin
            if ((int'(state_r.beat) * KEEP_W + k) < cpl_dw_total) begin
                cc_tkeep[k] = 1'b1;
            end
        end
    end

    always_comb begin
        state_nxt = state_r;
        state_nxt.mem_we = 1'b0;
        state_nxt.mem_rd = 1'b0;
        state_nxt.compl_done = 1'b0;
        // Turn-off part: acknowledge one cycle after turn_off_req is seen in ST_RX, even mid-receive.
        state_nxt.turn_off_ok = turn_off_req &&
            (state_r.st == ptre_pkg::ST_RX); // see [R13]
        case (state_r.st)
            ptre_pkg::ST_RX: begin
                if (take_beat) begin
                    for (int b = 0; b < HDR_BEATS; b++) begin
                        if (state_r.beat == 3'(b)) begin
                            state_nxt.hdr[b*DATA_W +: DATA_W] = cq_tdata;
                        end
                    end
                    // Beats past the descriptor are swallowed unread.
                    if (state_r.beat != BEAT_MAX) begin
                        state_nxt.beat = state_r.beat + 3'h1;
                    end
                    if (cq_tlast) begin
                        state_nxt.beat = ptre_pkg::BEAT_RST;
                        state_nxt.st = ptre_pkg::ST_DECODE; // see [R7]
                    end
                end
            end
            ptre_pkg::ST_DECODE: begin
                state_nxt.st = ptre_pkg::ST_RX;
                state_nxt.region = region_sel[1:0]; // see [R3]
                // Nine index bits make larger offsets wrap in the region.
                state_nxt.idx = state_r.hdr[ptre_pkg::CQ_ADDR_LO +:
                    ptre_pkg::IDX_W]; // see [R4] see [R17]
                state_nxt.wdata = state_r.hdr[ptre_pkg::CQ_DATA_LO +: 32];
                state_nxt.io_wr = (req_type == ptre_pkg::REQ_IO_WR);
                // Long or unmatched requests fall back to idle silently.
                if (one_dword && region_sel[2]) begin // see [R14]
                    if (is_write) begin
                        state_nxt.mem_we = 1'b1; // see [R16]
                        state_nxt.wr_busy = 1'b1; // see [R9]
                        state_nxt.st = ptre_pkg::ST_WRITE;
                    end else if (is_read) begin
                        state_nxt.mem_rd = 1'b1; // see [R4]
                        state_nxt.st = ptre_pkg::ST_READ;
                    end
                end
            end
            ptre_pkg::ST_WRITE: begin
                state_nxt.wr_busy = 1'b0; // see [R9]
                if (state_r.io_wr) begin
                    state_nxt.cpl = make_cpl(state_r.hdr, 1'b0, 32'h0,
                        COMPLETER_ID); // see [R16]
                    state_nxt.cpl_data = 1'b0;
                    state_nxt.st = ptre_pkg::ST_CPL;
                end else begin
                    state_nxt.st = ptre_pkg::ST_RX;
                end
            end
            ptre_pkg::ST_READ: begin
                state_nxt.cpl = make_cpl(state_r.hdr, 1'b1, rd_word,
                    COMPLETER_ID); // see [R5] see [R19]
                state_nxt.cpl_data = 1'b1;
                state_nxt.st = ptre_pkg::ST_CPL;
            end
            ptre_pkg::ST_CPL: begin
                if (cc_tready) begin
                    if (state_r.beat == CPL_LAST) begin
                        state_nxt.beat = ptre_pkg::BEAT_RST;
                        state_nxt.compl_done = 1'b1; // see [R8]
                        state_nxt.st = ptre_pkg::ST_RX;
                    end else begin
                        state_nxt.beat = state_r.beat + 3'h1;
                    end
                end
            end
            default: begin
                state_nxt.st = ptre_pkg::ST_RX;
            end
        endcase
    end

    // All-zero reset puts the machine idle with every flag clear.
    always_ff @(posedge clk_sys or negedge rst_int_n) begin
        if (!rst_int_n) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign cc_tvalid = (state_r.st == ptre_pkg::ST_CPL); // see [R5]
    assign cc_tlast = cc_tvalid && (state_r.beat == CPL_LAST);
    assign compl_done = state_r.compl_done; // see [R8]
    assign wr_busy = state_r.wr_busy; // see [R9]
    assign turn_off_ok = state_r.turn_off_ok; // see [R13]

endmodule

// >>> tb/ptre_checker_assertions.sv
// Handshake checks on the responder ports.
module ptre_checker (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic cq_tvalid,
    input wire logic cq_tlast,
    input wire logic req_channel_ready,
    input wire logic cc_tvalid,
    input wire logic cc_tlast,
    input wire logic cc_tready,
    input wire logic wr_busy,
    input wire logic compl_done,
    input wire logic turn_off_ok
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    take_drop_a: assert property (cq_tvalid && cq_tlast
        && req_channel_ready |=> !req_channel_ready) else $error("drop");
    cpl_stall_a: assert property (cc_tvalid |->
        !req_channel_ready) else $error("cpl");
    busy_stall_a: assert property (wr_busy |->
        !req_channel_ready) else $error("busy");
    done_after_cpl_a: assert property (compl_done |->
        $past(cc_tvalid && cc_tlast && cc_tready)) else $error("done");
    write_short_a: assert property (wr_busy |=>
        !wr_busy) else $error("write");
    cpl_hold_a: assert property (cc_tvalid && !cc_tready |=>
        cc_tvalid) else $error("hold");
    quiet_off_a: assert property (turn_off_ok |->
        !cc_tvalid) else $error("off");
    cover property (cc_tvalid);
    cover property (wr_busy);
    cover property (compl_done);
endmodule
bind ptre_engine ptre_checker u_ptre_checker (.*);

// >>> tb/ptre_core_sink.sv
// Completion sink in place of the core's transmit side.
module ptre_core_sink (
    input wire logic clk_sys,
    input wire logic stall,
    output logic cc_tready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic slow_r = 1'b0;
    // Alternate ready so every completion meets a slow sink.
    always @(posedge clk_sys) slow_r <= ~slow_r;
    assign cc_tready = !stall && slow_r;
endmodule

// >>> tb/testbench.sv
// Self-checking bench for the responder.
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin bad_count++; \
    $display("MISMATCH %0t %h %h", $time, a, e); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0, rst_n = 1'b0, cq_tvalid = 1'b0, stall = 1'b0;
    logic turn_off_req = 1'b0;
    logic [255:0] cq_tdata = '0, cc_tdata;
    logic [7:0] cc_tkeep;
    logic cc_tvalid, cc_tready, req_channel_ready, cc_tlast;
    logic compl_done, wr_busy, turn_off_ok, cfg_legal;
    int bad_count, n_checks, cyc;
    initial forever #2 clk_sys = ~clk_sys;
    ptre_engine #(.DATA_W(256)) u_ptre_engine(.clk_sys, .rst_n, .cq_tdata,
        .cq_tvalid, .cq_tlast(cq_tvalid), .req_channel_ready, .cc_tdata,
        .cc_tkeep, .cc_tvalid, .cc_tlast, .cc_tready, .compl_done,
        .wr_busy, .turn_off_req, .turn_off_ok, .cfg_legal);
    ptre_core_sink u_ptre_core_sink(.clk_sys, .stall, .cc_tready);
    task automatic send(logic [3:0] t, logic [2:0] w, logic [31:0] d,
            logic [10:0] n = 11'h001, logic far = 1'b0);
        @(negedge clk_sys);
        cq_tdata = '0;
        cq_tdata[2 +: 9] = 9'h1f;
        cq_tdata[11] = far;
        cq_tdata[64 +: 11] = n;
        cq_tdata[75 +: 4] = t;
        cq_tdata[96 +: 8] = 8'h5a;
        cq_tdata[112 +: 3] = w;
        cq_tdata[128 +: 32] = d;
        cq_tvalid = 1'b1;
        while (req_channel_ready !== 1'b1) @(negedge clk_sys);
        @(negedge clk_sys);
        cq_tvalid = 1'b0;
        `CHK(req_channel_ready, 1'b0)
    endtask
    task automatic rd(logic [2:0] w, logic [31:0] d, logic far = 1'b0);
        send(ptre_pkg::REQ_MEM_RD, w, 32'h0, 11'h001, far);
        while (!(cc_tvalid && cc_tready)) @(negedge clk_sys);
        `CHK(cc_tdata[96 +: 32], d)
        `CHK(cc_tdata[64 +: 8], 8'h5a)
        `CHK(cc_tkeep, 8'h0f)
        `CHK(cc_tlast, 1'b1)
        @(negedge clk_sys);
        `CHK(compl_done, 1'b1)
    endtask
    task automatic t_windows();
        logic [2:0] w[4] = '{3'h0, 3'h1, 3'h2, 3'h6};
        for (int i = 0; i < 4; i++)
            send(ptre_pkg::REQ_MEM_WR, w[i], 32'h100 + i);
        for (int i = 0; i < 4; i++) rd(w[i], 32'h100 + i);
    endtask
    task automatic t_stall();
        stall = 1'b1;
        send(ptre_pkg::REQ_IO_WR, 3'h0, 32'hcafe0001);
        repeat (6) @(negedge clk_sys);
        `CHK(req_channel_ready, 1'b0)
        `CHK(cc_tvalid, 1'b1)
        stall = 1'b0;
        while (!(cc_tvalid && cc_tready)) @(negedge clk_sys);
        `CHK(cc_tdata[32 +: 11], 11'h000)
        `CHK(cc_tkeep, 8'h07)
        rd(3'h0, 32'hcafe0001);
    endtask
    task automatic t_misc();
        send(ptre_pkg::REQ_MEM_WR, 3'h2, 32'h0badf00d, 11'h001, 1'b1);
        @(negedge clk_sys);
        `CHK(wr_busy, 1'b1)
        @(negedge clk_sys);
        `CHK(wr_busy, 1'b0)
        rd(3'h2, 32'h0badf00d);
        send(ptre_pkg::REQ_MEM_WR, 3'h2, 32'h12345678, 11'h002);
        send(ptre_pkg::REQ_MEM_RD, 3'h2, 32'h0, 11'h002);
        repeat (4) @(negedge clk_sys);
        `CHK(cc_tvalid, 1'b0)
        rd(3'h2, 32'h0badf00d, 1'b1);
        turn_off_req = 1'b1;
        @(negedge clk_sys);
        `CHK(turn_off_ok, 1'b1)
        turn_off_req = 1'b0;
        `CHK(cfg_legal, 1'b1)
    endtask
    task automatic t_reset();
        rst_n = 1'b0;
        repeat (2) @(negedge clk_sys);
        `CHK(req_channel_ready, 1'b0)
        rst_n = 1'b1;
        repeat (3) @(negedge clk_sys);
        `CHK(req_channel_ready, 1'b1)
        `CHK(cc_tvalid, 1'b0)
        rd(3'h1, 32'h101);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge clk_sys) if (++cyc > 3000) begin
        bad_count++;
        report_and_stop();
    end
    initial begin
        repeat (2) @(negedge clk_sys);
        rst_n = 1'b1;
        repeat (3) @(negedge clk_sys);
        t_windows();
        t_stall();
        t_misc();
        t_reset();
        report_and_stop();
    end
endmodule
